/* pkg/ans_params.svh */
`ifndef ANS_PARAMS_SVH
`define ANS_PARAMS_SVH

// Register addresses in the management space
`define ANS_ADDR_W 16
`define ANS_DATA_W 16
`define ANS_STATUS_ADDR 16'hfff9
`define ANS_MISC_ADDR 16'hfff8

// Status summary field positions
`define ANS_BIT_COMPLETE 15
`define ANS_BIT_LGC 14
`define ANS_BIT_ACK 13
`define ANS_BIT_ABIL 12
`define ANS_BIT_NPW 11
`define ANS_MODE_HI 10
`define ANS_MODE_LO 8
`define ANS_BIT_PDF 7
`define ANS_BIT_RFLT 6
`define ANS_BIT_PAGE 5
`define ANS_BIT_LP_AN 4
`define ANS_BIT_LP_NP 3
`define ANS_BIT_LINK 2
`define ANS_BIT_PAUSE_RX 1
`define ANS_BIT_PAUSE_TX 0

// Miscellaneous control shadow fields
`define ANS_MISC_WREN 15
`define ANS_MISC_RSEL_HI 14
`define ANS_MISC_RSEL_LO 12
`define ANS_MISC_FMDIX 9
`define ANS_MISC_SSEL_HI 2
`define ANS_MISC_SSEL_LO 0
`define ANS_SHADOW_MISC 3'h7

// Reset values
`define ANS_RST_WORD 16'h0000
`define ANS_RST_RSEL 3'h0
`define ANS_RST_FMDIX 1'h0
`define ANS_RST_STATE 3'h0
`define ANS_RST_AUTO_MDIX 1'h1

`endif

/* pkg/ans_pkg.sv */
package ans_pkg;

   // State codes presented by the negotiation state machine
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ABILITY_DETECT = 3'h1,
      ST_ACK_DETECT = 3'h2,
      ST_COMPLETE_ACK = 3'h3,
      ST_NP_WAIT = 3'h4,
      ST_LINK_GOOD_CHECK = 3'h5,
      ST_LINK_GOOD = 3'h6,
      ST_OTHER = 3'h7
   } ans_an_state_e;

   // Resolved speed and duplex encoding of the mode field
   typedef enum logic [2:0] {
      MODE_NONE = 3'h0,
      MODE_RSVD1 = 3'h1,
      MODE_RSVD2 = 3'h2,
      MODE_100TX_HD = 3'h3,
      MODE_100T4 = 3'h4,
      MODE_100TX_FD = 3'h5,
      MODE_1000T_HD = 3'h6,
      MODE_1000T_FD = 3'h7
   } ans_mode_e;

   // Manually selected speed
   typedef enum logic [1:0] {
      SPD_10 = 2'h0,
      SPD_100 = 2'h1,
      SPD_1000 = 2'h2,
      SPD_RSVD = 2'h3
   } ans_speed_e;

endpackage

/* hw/ans_sticky.sv */
`timescale 1ns/1ps
`default_nettype none

// One latch-high flag that clears when the status word is read
module ans_sticky (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);

   logic flag_r;
   logic flag_nxt;

   // Set beats clear so an event in the read cycle survives
   always_comb
   begin
      flag_nxt = set_i | (flag_r & ~clr_i);
   end

   // Flag storage, frozen while the clock enable is low
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         flag_r <= 1'b0;
      end
      else if (ce_i)
      begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_o = flag_r;

endmodule // ans_sticky

`default_nettype wire

/* hw/ans_top.sv */
// Functional notes
// - Bit 15 reads one once negotiation completes, zero while it runs.
// - Bit 14 latches when the link-good-check state is entered.
// - Bit 13 latches when the acknowledge-detect state is entered.
// - Bit 12 latches when the ability-detect state is entered.
// - Bit 11 latches when the next-page wait state is entered.
// - Latched entry flags hold until read, then clear unless re-entered.
// - Bits 10:8 carry the resolved speed and duplex code.
// - Mode field reads 000 without common mode or before completion.
// - Negotiation off, forced crossover clear: mode shows manual speed and duplex.
// - Negotiation off, forced crossover set: mode field reads 000.
// - Bit 7 latches a parallel-detection fault until the next read.
// - Bit 6 follows the partner's remote fault indication.
// - Bit 5 latches a newly received partner page until read.
// - Bit 4 shows the partner is known to negotiate.
// - Bit 3 shows the partner advertises next-page capability.
// - Bit 2 is one in link pass, zero in link fail.
// - Bit 1 shows pause receive permitted by resolution.
// - Bit 0 shows pause transmit permitted by resolution.
// - Forced crossover bit 9 enables auto crossover while negotiation is off.
//
// Decided for this implementation: strobed register access.
`include "ans_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ans_top (
   // Clock, reset and clock enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Register port
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rd_data_o,
   // Negotiation state machine
   input wire logic an_enable_i,
   input wire logic an_complete_i,
   input wire logic [2:0] an_state_i,
   input wire logic [2:0] best_common_mode_i,
   input wire logic parallel_fault_i,
   input wire logic page_received_i,
   input wire logic lp_remote_fault_i,
   input wire logic lp_an_able_i,
   input wire logic lp_np_able_i,
   input wire logic pause_rx_i,
   input wire logic pause_tx_i,
   // Manual mode selection
   input wire logic [1:0] manual_speed_i,
   input wire logic manual_full_duplex_i,
   // Link monitor
   input wire logic link_pass_i,
   // Crossover control and mode field towards the line side
   output logic auto_mdix_en_o,
   output logic [2:0] mode_o
);

   // Four state-entry flags and two event flags
   localparam int NUM_FLAGS = 6;

   // Flag indices in the sticky vector
   localparam int FL_LGC = 0;
   localparam int FL_ACK = 1;
   localparam int FL_ABIL = 2;
   localparam int FL_NPW = 3;
   localparam int FL_PDF = 4;
   localparam int FL_PAGE = 5;

   // Internal registers and nets
   logic [2:0] prev_state_r;
   logic state_valid_r;
   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_q;
   logic status_read;
   logic misc_read;
   logic misc_write;
   logic [2:0] rsel_r;
   logic force_mdix_r;
   logic [2:0] manual_mode;
   logic [2:0] neg_mode;
   logic [2:0] mode_nxt;
   logic [15:0] status_word;
   logic [15:0] misc_word;
   logic [15:0] rd_data_nxt;
   logic [15:0] rd_data_r;
   logic [2:0] mode_r;
   logic auto_mdix_r;

   // Register port decode
   always_comb
   begin
      status_read = 1'b0;
      misc_read = 1'b0;
      misc_write = 1'b0;
      if (rd_i && (addr_i == `ANS_STATUS_ADDR))
      begin
         status_read = 1'b1;
      end
      else if (rd_i && (addr_i == `ANS_MISC_ADDR))
      begin
         misc_read = 1'b1;
      end
      else if (wr_i && (addr_i == `ANS_MISC_ADDR))
      begin
         misc_write = 1'b1;
      end
   end

   // Previous state, so that only a fresh entry raises a flag
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         prev_state_r <= `ANS_RST_STATE;
      end
      else if (ce_i)
      begin
         prev_state_r <= an_state_i;
      end
   end

   // First live cycle marker, so a state held through reset counts as entered
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_valid_r <= 1'b0;
      end
      else if (ce_i)
      begin
         state_valid_r <= 1'b1;
      end
   end

   // Entry events: the state is the target now and was not before
   always_comb
   begin
      flag_set = '0;
      flag_set[FL_LGC] = (an_state_i == ans_pkg::ST_LINK_GOOD_CHECK)
         && (!state_valid_r || (prev_state_r != an_state_i));
      flag_set[FL_ACK] = (an_state_i == ans_pkg::ST_ACK_DETECT)
         && (!state_valid_r || (prev_state_r != an_state_i));
      flag_set[FL_ABIL] = (an_state_i == ans_pkg::ST_ABILITY_DETECT)
         && (!state_valid_r || (prev_state_r != an_state_i));
      flag_set[FL_NPW] = (an_state_i == ans_pkg::ST_NP_WAIT)
         && (!state_valid_r || (prev_state_r != an_state_i));
      flag_set[FL_PDF] = parallel_fault_i;
      flag_set[FL_PAGE] = page_received_i;
   end

   // One latch-high flag per event, all cleared by a status read
   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi++)
      begin : g_flag
         ans_sticky u_sticky (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .set_i(flag_set[gi]),
            .clr_i(status_read),
            .flag_o(flag_q[gi])
         );
      end
   endgenerate

   // Read selector, written on every write to the misc shadow
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rsel_r <= `ANS_RST_RSEL;
      end
      else if (ce_i && misc_write
         && (wr_data_i[`ANS_MISC_SSEL_HI:`ANS_MISC_SSEL_LO] == `ANS_SHADOW_MISC))
      begin
         rsel_r <= wr_data_i[`ANS_MISC_RSEL_HI:`ANS_MISC_RSEL_LO];
      end
   end

   // Forced crossover bit, changed only while the write enable bit is set
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         force_mdix_r <= `ANS_RST_FMDIX;
      end
      else if (ce_i && misc_write && wr_data_i[`ANS_MISC_WREN]
         && (wr_data_i[`ANS_MISC_SSEL_HI:`ANS_MISC_SSEL_LO] == `ANS_SHADOW_MISC))
      begin
         force_mdix_r <= wr_data_i[`ANS_MISC_FMDIX];
      end
   end

   // Manually selected speed and duplex in mode-field encoding
   always_comb
   begin
      manual_mode = ans_pkg::MODE_NONE;
      case (manual_speed_i)
         ans_pkg::SPD_1000:
         begin
            manual_mode = manual_full_duplex_i ? ans_pkg::MODE_1000T_FD
               : ans_pkg::MODE_1000T_HD;
         end
         ans_pkg::SPD_100:
         begin
            manual_mode = manual_full_duplex_i ? ans_pkg::MODE_100TX_FD
               : ans_pkg::MODE_100TX_HD;
         end
         ans_pkg::SPD_10:
         begin
            manual_mode = ans_pkg::MODE_NONE; // No code exists for 10 Mb/s
         end
         default:
         begin
            manual_mode = ans_pkg::MODE_NONE;
         end
      endcase
   end

   // Negotiated mode; reserved codes never reach software
   always_comb
   begin
      neg_mode = best_common_mode_i;
      if ((best_common_mode_i == ans_pkg::MODE_RSVD1)
         || (best_common_mode_i == ans_pkg::MODE_RSVD2))
      begin
         neg_mode = ans_pkg::MODE_NONE;
      end
   end

   // Mode field selection between negotiated and manual results
   always_comb
   begin
      mode_nxt = ans_pkg::MODE_NONE;
      if (an_enable_i)
      begin
         mode_nxt = an_complete_i ? neg_mode : ans_pkg::MODE_NONE;
      end
      else if (force_mdix_r)
      begin
         mode_nxt = ans_pkg::MODE_NONE;
      end
      else
      begin
         mode_nxt = manual_mode;
      end
   end

   // Assembly of the status summary word
   always_comb
   begin
      status_word = `ANS_RST_WORD;
      status_word[`ANS_BIT_COMPLETE] = an_complete_i;
      status_word[`ANS_BIT_LGC] = flag_q[FL_LGC];
      status_word[`ANS_BIT_ACK] = flag_q[FL_ACK];
      status_word[`ANS_BIT_ABIL] = flag_q[FL_ABIL];
      status_word[`ANS_BIT_NPW] = flag_q[FL_NPW];
      status_word[`ANS_MODE_HI:`ANS_MODE_LO] = mode_nxt;
      status_word[`ANS_BIT_PDF] = flag_q[FL_PDF];
      status_word[`ANS_BIT_RFLT] = lp_remote_fault_i;
      status_word[`ANS_BIT_PAGE] = flag_q[FL_PAGE];
      status_word[`ANS_BIT_LP_AN] = lp_an_able_i;
      status_word[`ANS_BIT_LP_NP] = lp_np_able_i;
      status_word[`ANS_BIT_LINK] = link_pass_i;
      status_word[`ANS_BIT_PAUSE_RX] = pause_rx_i;
      status_word[`ANS_BIT_PAUSE_TX] = pause_tx_i;
   end

   // Misc control readback when its shadow is selected, zero otherwise
   always_comb
   begin
      misc_word = `ANS_RST_WORD;
      if (rsel_r == `ANS_SHADOW_MISC)
      begin
         misc_word[`ANS_MISC_RSEL_HI:`ANS_MISC_RSEL_LO] = rsel_r;
         misc_word[`ANS_MISC_FMDIX] = force_mdix_r;
         misc_word[`ANS_MISC_SSEL_HI:`ANS_MISC_SSEL_LO] = `ANS_SHADOW_MISC;
      end
   end

   // Read data mux; unmapped reads and idle cycles return zero
   always_comb
   begin
      rd_data_nxt = `ANS_RST_WORD;
      if (status_read)
      begin
         rd_data_nxt = status_word;
      end
      else if (misc_read)
      begin
         rd_data_nxt = misc_word;
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rd_data_r <= `ANS_RST_WORD;
      end
      else if (ce_i)
      begin
         rd_data_r <= rd_data_nxt;
      end
   end

   // Registered copy of the mode field for the line side
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mode_r <= ans_pkg::MODE_NONE;
      end
      else if (ce_i)
      begin
         mode_r <= mode_nxt;
      end
   end

   // Crossover enable: always on with negotiation, else the forced bit decides
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         auto_mdix_r <= `ANS_RST_AUTO_MDIX;
      end
      else if (ce_i)
      begin
         auto_mdix_r <= an_enable_i | force_mdix_r;
      end
   end

   // Outputs driven straight from flip-flops
   assign rd_data_o = rd_data_r;
   assign mode_o = mode_r;
   assign auto_mdix_en_o = auto_mdix_r;

endmodule // ans_top

`default_nettype wire

/* bench/ans_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the status summary block
module ans_top_asserts (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [15:0] addr_i,
   input wire logic rd_i,
   input wire logic an_enable_i,
   input wire logic an_complete_i,
   input wire logic [2:0] best_common_mode_i,
   input wire logic page_received_i,
   input wire logic lp_remote_fault_i,
   input wire logic lp_an_able_i,
   input wire logic lp_np_able_i,
   input wire logic link_pass_i,
   input wire logic pause_rx_i,
   input wire logic pause_tx_i,
   input wire logic [1:0] manual_speed_i,
   input wire logic manual_full_duplex_i,
   input wire logic [15:0] rd_data_o,
   input wire logic auto_mdix_en_o,
   input wire logic [2:0] mode_o
);
   logic ok_q;
   logic st_q;

   // Live previous edge, and a status read taken at it
   always_ff @(posedge clk_i)
   begin
      ok_q <= rst_n_i & ce_i;
      st_q <= rst_n_i & ce_i & rd_i & (addr_i == 16'hfff9);
   end

   // Manual speed and duplex code
   function automatic logic [2:0] man_f(input logic [1:0] s, input logic f);
      return (s == 2'h2) ? {2'h3, f} : (s == 2'h1) ? (f ? 3'h5 : 3'h3) : 3'h0;
   endfunction

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   idle_data_a: assert property (ok_q && !$past(rd_i) |-> rd_data_o == 16'h0000)
      else $error("read data not zero outside answer cycle");
   unmapped_rd_a: assert property (ok_q && $past(rd_i && addr_i != 16'hfff9
      && addr_i != 16'hfff8) |-> rd_data_o == 16'h0000)
      else $error("unmapped read not zero");
   cmpl_bit_a: assert property (st_q |-> rd_data_o[15] == $past(an_complete_i))
      else $error("completion bit wrong");
   level_bits_a: assert property (st_q |-> {rd_data_o[6], rd_data_o[4:0]} ==
      $past({lp_remote_fault_i, lp_an_able_i, lp_np_able_i, link_pass_i, pause_rx_i, pause_tx_i}))
      else $error("level status bits wrong");
   event_flag_a: assert property (st_q && $past(ok_q) && $past(page_received_i, 2)
      |-> rd_data_o[5])
      else $error("page flag lost");
   field_mode_a: assert property (st_q |-> rd_data_o[10:8] == mode_o)
      else $error("mode field differs from mode output");
   mode_off_a: assert property (ok_q && $past(an_enable_i && !an_complete_i)
      |-> mode_o == 3'h0)
      else $error("mode not zero before completion");
   mode_neg_a: assert property (ok_q && $past(an_enable_i && an_complete_i) |->
      mode_o == (($past(best_common_mode_i) inside {3'h1, 3'h2}) ? 3'h0 : $past(best_common_mode_i)))
      else $error("negotiated mode wrong");
   mode_manual_a: assert property (ok_q && $past(!an_enable_i) |-> mode_o ==
      (auto_mdix_en_o ? 3'h0 : man_f($past(manual_speed_i), $past(manual_full_duplex_i))))
      else $error("manual mode wrong");
   mdix_on_a: assert property (ok_q && $past(an_enable_i) |-> auto_mdix_en_o)
      else $error("crossover not enabled with negotiation");

endmodule // ans_top_asserts

bind ans_top ans_top_asserts i_chk (.clk_i, .rst_n_i, .ce_i, .addr_i, .rd_i, .an_enable_i,
   .an_complete_i, .best_common_mode_i, .page_received_i, .lp_remote_fault_i, .lp_an_able_i,
   .lp_np_able_i, .link_pass_i, .pause_rx_i, .pause_tx_i, .manual_speed_i,
   .manual_full_duplex_i, .rd_data_o, .auto_mdix_en_o, .mode_o);

`default_nettype wire

/* bench/ans_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module ans_top_tb;
   logic clk_i, rst_n_i, ce_i, wr_i, rd_i, an_enable_i, an_complete_i, hit;
   logic parallel_fault_i, page_received_i, manual_full_duplex_i, auto_mdix_en_o;
   logic lp_remote_fault_i, lp_an_able_i, lp_np_able_i, link_pass_i, pause_rx_i, pause_tx_i;
   logic [15:0] addr_i, wr_data_i, rd_data_o, v;
   logic [2:0] an_state_i, best_common_mode_i, mode_o;
   logic [1:0] manual_speed_i;
   logic [5:0] lv;
   logic [2:0] st [4] = '{3'h5, 3'h2, 3'h1, 3'h4};
   int bt [4] = '{14, 13, 12, 11};
   logic [2:0] ex [8] = '{3'h0, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7, 3'h0, 3'h0};
   int bad_count, n_tests;

   assign {lp_remote_fault_i, lp_an_able_i, lp_np_able_i, link_pass_i, pause_rx_i, pause_tx_i} = lv;

   ans_top i_dut (.clk_i, .rst_n_i, .ce_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
      .an_enable_i, .an_complete_i, .an_state_i, .best_common_mode_i, .parallel_fault_i,
      .page_received_i, .lp_remote_fault_i, .lp_an_able_i, .lp_np_able_i, .pause_rx_i,
      .pause_tx_i, .manual_speed_i, .manual_full_duplex_i, .link_pass_i, .auto_mdix_en_o,
      .mode_o);

   // Clock at 100 MHz
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask

   // One-cycle write strobe
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // One-cycle read strobe, data taken at the edge that closes the answer cycle
   task rc(input string nm, input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      parallel_fault_i <= hit;
      page_received_i <= 1'b0;
      @(posedge clk_i);
      rd_i <= 1'b0;
      parallel_fault_i <= 1'b0;
      @(posedge clk_i);
      v = rd_data_o;
      chk(nm, v, exp);
   endtask

   task end_of_test();
      if (bad_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {rst_n_i, wr_i, rd_i, an_enable_i, an_complete_i, hit} = '0;
      {parallel_fault_i, page_received_i, manual_full_duplex_i} = '0;
      {addr_i, wr_data_i, an_state_i, best_common_mode_i, manual_speed_i, lv} = '0;
      ce_i = 1'b1;
      bad_count = 0;
      n_tests = 0;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rc("status reset", 16'hfff9, 16'h0000);
      rc("misc reset", 16'hfff8, 16'h0000);
      wr(16'h0001, 16'hffff);
      rc("unmapped", 16'h0001, 16'h0000);
      chk("mdix off", {15'h0, auto_mdix_en_o}, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_i);
         an_state_i <= st[i];
         rc("entry flag", 16'hfff9, 16'h1 << bt[i]);
         rc("entry held", 16'hfff9, 16'h0000);
         an_state_i <= 3'h0;
      end
      hit = 1'b1;
      rc("fault in read", 16'hfff9, 16'h0000);
      hit = 1'b0;
      rc("fault kept", 16'hfff9, 16'h0080);
      rc("fault cleared", 16'hfff9, 16'h0000);
      page_received_i <= 1'b1;
      rc("page in read", 16'hfff9, 16'h0020);
      @(posedge clk_i);
      page_received_i <= 1'b1;
      @(posedge clk_i);
      page_received_i <= 1'b0;
      ce_i <= 1'b0;
      rc("frozen read", 16'hfff9, 16'h0000);
      ce_i <= 1'b1;
      rc("page", 16'hfff9, 16'h0020);
      rc("page cleared", 16'hfff9, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         lv <= 6'h1 << i;
         rc("level bit", 16'hfff9, (i == 5) ? 16'h0040 : (16'h1 << i));
      end
      lv <= 6'h0;
      an_enable_i <= 1'b1;
      best_common_mode_i <= 3'h7;
      rc("incomplete", 16'hfff9, 16'h0000);
      an_complete_i <= 1'b1;
      for (int m = 0; m < 8; m++)
      begin
         best_common_mode_i <= 3'(m);
         rc("mode", 16'hfff9, {1'b1, 4'h0, (m == 1 || m == 2) ? 3'h0 : 3'(m), 8'h00});
      end
      lv <= 6'h3;
      rc("pause valid", 16'hfff9, 16'h8703);
      lv <= 6'h0;
      chk("mdix an", {15'h0, auto_mdix_en_o}, 16'h0001);
      {an_enable_i, an_complete_i} <= 2'b00;
      for (int s = 0; s < 8; s++)
      begin
         {manual_speed_i, manual_full_duplex_i} <= 3'(s);
         rc("manual", 16'hfff9, {5'h0, ex[s], 8'h00});
         chk("mode out", {13'h0, mode_o}, {13'h0, ex[s]});
      end
      {manual_speed_i, manual_full_duplex_i} <= 3'h5;
      wr(16'hfff8, 16'hf207);
      rc("misc", 16'hfff8, 16'h7207);
      rc("forced", 16'hfff9, 16'h0000);
      chk("mdix forced", {15'h0, auto_mdix_en_o}, 16'h0001);
      wr(16'hfff8, 16'h7007);
      rc("misc kept", 16'hfff8, 16'h7207);
      wr(16'hfff8, 16'hf007);
      rc("manual back", 16'hfff9, 16'h0700);
      chk("mdix cleared", {15'h0, auto_mdix_en_o}, 16'h0000);
      end_of_test();
   end

endmodule // ans_top_tb

`default_nettype wire
